// File: pkg/src_consts.svh
// timing counts and fixed addresses of the reset controller
`ifndef SRC_CONSTS_SVH
`define SRC_CONSTS_SVH
`define SRC_CLK_MHZ        40
`define SRC_PIN_MIN_CYC    3
`define SRC_POR_CYC        4'hF
`define SRC_POR_XTAL_CYC   16'h1000
`define SRC_VEC_HI_ADDR    16'h0002
`define SRC_VEC_LO_ADDR    16'h0003
`define SRC_UNIMPL_DATA    8'hFF
`define SRC_PMEM_TOP       16'h0FFF
`endif

// File: pkg/src_pkg.sv
// types of the reset controller
package src_pkg;
   typedef enum logic [1:0] {
      SRC_RUN,
      SRC_HOLD,
      SRC_VEC_HI,
      SRC_VEC_LO
   } src_state_t;
   typedef struct packed {
      src_state_t state;
      logic [15:0] count;
      logic        from_por;
   } src_seq_t;
endpackage : src_pkg

// File: pkg/src_sync_if.sv
// synchronised pin levels passed to the filter
`timescale 1ns/1ps
interface src_sync_if;
   logic pin_low;
   logic pulse_ok;
   modport filt (input pin_low, output pulse_ok);
   modport top  (output pin_low, input pulse_ok);
endinterface : src_sync_if

// File: rtl/src_pin_filter.sv
// pulse-width filter for the reset pin
`timescale 1ns/1ps
`include "src_consts.svh"
module src_pin_filter
   import src_pkg::*;
#(
   parameter int MIN_CYC = `SRC_PIN_MIN_CYC
)(
   input  wire logic mclk_i,
   input  wire logic reset_n_i,
   src_sync_if.filt  sif
);
   logic [3:0] run;
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i || !sif.pin_low) begin
         run <= 4'h0;
      end else if (run != 4'hF) begin
         run <= run + 4'h1;
      end
   end
   // accepted once low for the minimum width
   assign sif.pulse_ok = sif.pin_low && (run >= 4'(MIN_CYC - 1));
   pulse_width_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      sif.pulse_ok |-> $past(sif.pin_low, 2))
      else $error("pin pulse accepted too short");
endmodule : src_pin_filter

// File: rtl/src_reset_ctrl.sv
// system reset controller top
`timescale 1ns/1ps
`include "src_consts.svh"
module src_reset_ctrl
   import src_pkg::*;
#(
   parameter int POR_CYC  = `SRC_POR_CYC,
   parameter int XTAL_CYC = `SRC_POR_XTAL_CYC
)(
   input  wire logic        mclk_i,
   input  wire logic        reset_n_i,
   input  wire logic        supply_ok_i,
   input  wire logic        brown_out_i,
   input  wire logic        reset_pin_i,
   output logic             reset_pin_o,
   output logic             reset_pin_oe_o,
   input  wire logic        stop_mode_i,
   input  wire logic        stop_pin_ok_i,
   input  wire logic        debug_pin_i,
   input  wire logic        watchdog_timeout_i,
   input  wire logic        watchdog_reset_mode_i,
   input  wire logic        debugger_reset_i,
   input  wire logic        xtal_enable_i,
   input  wire logic        por_flag_clear_i,
   output logic             por_flag_o,
   output logic             sys_reset_n_o,
   output logic             debugger_reset_n_o,
   output logic             vec_fetch_o,
   output logic [15:0]      vec_addr_o,
   input  wire logic [7:0]  vec_data_i,
   output logic [15:0]      start_addr_o,
   output logic             start_valid_o,
   input  wire logic [15:0] pmem_addr_i,
   input  wire logic        pmem_impl_i,
   input  wire logic [7:0]  pmem_raw_i,
   output logic [7:0]       pmem_rdata_o,
   output logic             pmem_we_ok_o
);
   src_seq_t   q;
   src_seq_t   next_q;
   logic [1:0] s_pin, s_dbg, s_sup, s_bo, s_spk;
   logic       por_flag;
   logic [15:0] start_addr;
   logic       start_valid;
   src_sync_if sif ();

   // two-stage synchronisers for pin and analog inputs
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         s_pin <= 2'h3;
         s_dbg <= 2'h3;
         s_sup <= 2'h0;
         s_bo  <= 2'h0;
         s_spk <= 2'h0;
      end else begin
         s_pin <= {s_pin[0], reset_pin_i};
         s_dbg <= {s_dbg[0], debug_pin_i};
         s_sup <= {s_sup[0], supply_ok_i};
         s_bo  <= {s_bo[0], brown_out_i};
         s_spk <= {s_spk[0], stop_pin_ok_i};
      end
   end

   assign sif.pin_low = !s_pin[1];
   src_pin_filter #(.MIN_CYC(`SRC_PIN_MIN_CYC)) u_filt (
      .mclk_i    (mclk_i),
      .reset_n_i (reset_n_i),
      .sif       (sif)
   );

   logic power_bad;
   logic src_run;
   logic src_stop;
   logic any_src;
   logic pin_live;
   logic pin_src;
   logic hold_src;
   // own pin drive must not look like a new pin reset after release
   assign pin_live = (q.state == SRC_RUN) && (q.count >= 16'h0003);
   assign power_bad = !s_sup[1] || s_bo[1];
   assign pin_src = pin_live && (stop_mode_i ?
                    (sif.pin_low && s_spk[1]) : sif.pulse_ok);
   assign src_run = !stop_mode_i &&
      ((watchdog_timeout_i && watchdog_reset_mode_i)
      || debugger_reset_i);
   assign src_stop = stop_mode_i && !s_dbg[1];
   assign hold_src = power_bad || src_run || src_stop;
   assign any_src = hold_src || pin_src;

   always_comb begin
      next_q = q;
      case (q.state)
         SRC_RUN: begin
            if (any_src) begin
               next_q.state    = SRC_HOLD;
               next_q.count    = 16'h0;
               next_q.from_por = power_bad;
            end else if (q.count < 16'h0003) begin
               next_q.count = q.count + 16'h1;
            end
         end
         SRC_HOLD: begin
            if (power_bad) begin
               next_q.count    = 16'h0;
               next_q.from_por = 1'b1;
            end else if (hold_src) begin
               next_q.count = 16'h0;
            end else if (next_q.from_por && q.count <
                         (xtal_enable_i ? 16'(XTAL_CYC) : 16'(POR_CYC)))
            begin
               next_q.count = q.count + 16'h1;
            end else begin
               next_q.state = SRC_VEC_HI;
            end
         end
         SRC_VEC_HI: begin
            if (power_bad) begin
               next_q.state    = SRC_HOLD;
               next_q.count    = 16'h0;
               next_q.from_por = 1'b1;
            end else begin
               next_q.state = SRC_VEC_LO;
            end
         end
         SRC_VEC_LO: begin
            if (power_bad) begin
               next_q.state    = SRC_HOLD;
               next_q.count    = 16'h0;
               next_q.from_por = 1'b1;
            end else begin
               next_q.state = SRC_RUN;
               next_q.count = 16'h0;
            end
         end
         default:    next_q.state = SRC_HOLD;
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         q <= '{state: SRC_HOLD, count: 16'h0, from_por: 1'b1};
      end else begin
         q <= next_q;
      end
   end

   // vector capture and power-on flag
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         start_addr  <= 16'h0000;
         start_valid <= 1'b0;
         por_flag    <= 1'b0;
      end else begin
         if (q.state == SRC_HOLD) begin
            start_valid <= 1'b0;
         end
         if (q.state == SRC_VEC_HI) begin
            start_addr[15:8] <= vec_data_i;
         end
         if (q.state == SRC_VEC_LO) begin
            start_addr[7:0] <= vec_data_i;
            start_valid     <= 1'b1;
         end
         if (q.state == SRC_VEC_LO && q.from_por) begin
            por_flag <= 1'b1;
         end else if (por_flag_clear_i) begin
            por_flag <= 1'b0;
         end
      end
   end

   assign sys_reset_n_o  = (q.state == SRC_RUN);
   assign debugger_reset_n_o = !(q.state != SRC_RUN && q.from_por);
   assign reset_pin_o    = 1'b0;
   assign reset_pin_oe_o = (q.state != SRC_RUN);
   assign vec_fetch_o    = (q.state == SRC_VEC_HI) ||
                           (q.state == SRC_VEC_LO);
   assign vec_addr_o     = (q.state == SRC_VEC_LO) ?
                           `SRC_VEC_LO_ADDR : `SRC_VEC_HI_ADDR;
   assign start_addr_o   = start_addr;
   assign start_valid_o  = start_valid;
   assign por_flag_o     = por_flag;
   // unimplemented space reads ones, writes blocked
   assign pmem_rdata_o = (pmem_impl_i && pmem_addr_i <= `SRC_PMEM_TOP) ?
                         pmem_raw_i : `SRC_UNIMPL_DATA;
   assign pmem_we_ok_o = pmem_impl_i && pmem_addr_i <= `SRC_PMEM_TOP;

   wdt_reset_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (q.state == SRC_RUN && !stop_mode_i && watchdog_timeout_i &&
       watchdog_reset_mode_i) |=> !sys_reset_n_o)
      else $error("watchdog reset not taken");
   dbg_reset_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (q.state == SRC_RUN && !stop_mode_i && debugger_reset_i)
      |=> (!sys_reset_n_o && debugger_reset_n_o))
      else $error("debugger reset wrong");
   stop_dbg_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (q.state == SRC_RUN && stop_mode_i && !s_dbg[1]) |=> !sys_reset_n_o)
      else $error("debug pin low in stop ignored");
   supply_hold_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      power_bad |=> !sys_reset_n_o [*2])
      else $error("released while supply low");
   sequence vec_seq;
      q.state == SRC_VEC_HI ##1 q.state == SRC_VEC_LO ##1 sys_reset_n_o;
   endsequence
   vec_fetch_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (q.state == SRC_HOLD && next_q.state == SRC_VEC_HI) |=> vec_seq)
      else $error("vector fetch order wrong");
   por_flag_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (q.state == SRC_VEC_LO && q.from_por) |=> por_flag_o)
      else $error("power-on flag not set");
   unimpl_read_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      !pmem_impl_i |-> (pmem_rdata_o == 8'hFF && !pmem_we_ok_o))
      else $error("unimplemented access wrong");
   pin_drive_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      !sys_reset_n_o |-> (reset_pin_oe_o && !reset_pin_o))
      else $error("reset pin not driven");
   por_delay_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (q.state == SRC_HOLD && q.from_por && q.count == 16'h0 && !any_src)
      |=> !sys_reset_n_o [*8])
      else $error("power-on delay too short");
endmodule : src_reset_ctrl

// File: sim/src_far_model.sv
// far side: reset pin wiring and reset vector memory
`timescale 1ns/1ps
module src_far_model #(
   parameter logic [15:0] VEC = 16'h1A5C
)(
   input  wire logic        oe_i,
   input  wire logic        drv_i,
   input  wire logic        ext_low_i,
   input  wire logic [15:0] addr_i,
   output logic             pin_o,
   output logic [7:0]       data_o
);
   // pull-up unless a party drives low
   assign pin_o = !((oe_i && !drv_i) || ext_low_i);
   // high byte at 0002, low byte at 0003
   assign data_o = (addr_i == 16'h0002) ? VEC[15:8] :
                   (addr_i == 16'h0003) ? VEC[7:0] : ~addr_i[7:0];
endmodule : src_far_model

// File: sim/tb.sv
// testbench of the reset controller
`timescale 1ns/1ps
module tb;
   import src_pkg::*;
   localparam int POR = 8;
   localparam int XT = 16;
   logic mclk_i = 0, reset_n_i = 0, sup = 0, bo = 0, ext = 0, stp = 0;
   logic sok = 0, dbp = 1, wdt = 0, wdm = 1, dbr = 0, xt = 0, clr = 0;
   logic impl = 0, pin, pdrv, oe, pf, sys_n, dbg_n, vf, sv, we;
   logic [15:0] pa = 0, va, sa;
   logic [7:0] raw = 0, vd, rd;
   logic seen = 0, dseen = 0, oseen = 0;
   int err_total = 0, n_checks = 0, seed = 32'hbfad, n;
   src_reset_ctrl #(.POR_CYC(POR), .XTAL_CYC(XT)) dut (.mclk_i(mclk_i),
      .reset_n_i(reset_n_i), .supply_ok_i(sup), .brown_out_i(bo),
      .reset_pin_i(pin), .reset_pin_o(pdrv), .reset_pin_oe_o(oe),
      .stop_mode_i(stp), .stop_pin_ok_i(sok), .debug_pin_i(dbp),
      .watchdog_timeout_i(wdt), .watchdog_reset_mode_i(wdm),
      .debugger_reset_i(dbr), .xtal_enable_i(xt), .por_flag_clear_i(clr),
      .por_flag_o(pf), .sys_reset_n_o(sys_n), .debugger_reset_n_o(dbg_n),
      .vec_fetch_o(vf), .vec_addr_o(va), .vec_data_i(vd),
      .start_addr_o(sa), .start_valid_o(sv), .pmem_addr_i(pa),
      .pmem_impl_i(impl), .pmem_raw_i(raw), .pmem_rdata_o(rd),
      .pmem_we_ok_o(we));
   src_far_model far (.oe_i(oe), .drv_i(pdrv), .ext_low_i(ext),
      .addr_i(va), .pin_o(pin), .data_o(vd));
   initial begin
      forever #12.5 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i) begin
      if (!sys_n) seen <= 1'b1;
      if (!dbg_n) dseen <= 1'b1;
      if (oe) oseen <= 1'b1;
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : wrap_up
   task automatic to_run(output int c);
      c = 0;
      while (sys_n !== 1'b1 && c < 200) begin
         @(negedge mclk_i);
         c++;
      end
   endtask : to_run
   task automatic set_src(input int s, input logic v);
      case (s)
         0: ext = v;
         1: wdt = v;
         2: dbr = v;
         3: begin ext = v; sok = v; end
         default: dbp = !v;
      endcase
   endtask : set_src
   // apply a source for len cycles, then see whether a reset ran
   task automatic hit(input int s, input int len, input logic exp);
      int c;
      @(negedge mclk_i);
      {seen, dseen, oseen} = 3'b000;
      repeat (len) begin
         set_src(s, 1'b1);
         @(negedge mclk_i);
      end
      set_src(s, 1'b0);
      repeat (12) @(negedge mclk_i);
      check(seen, exp);
      check(oseen, exp);
      check(dseen, 0);
      to_run(c);
      check(sys_n, 1);
      if (exp) check(sa, 16'h1A5C);
      $display("source %0d length %0d done", s, len);
   endtask : hit
   initial begin
      repeat (5000) @(posedge mclk_i);
      err_total++;
      wrap_up();
   end
   initial begin
      repeat (3) @(negedge mclk_i);
      reset_n_i = 1;
      repeat (30) @(negedge mclk_i);
      check(sys_n, 0);
      check(dbg_n, 0);
      sup = 1;
      to_run(n);
      check(n >= POR && n <= POR + 8, 1);
      check(sa, 16'h1A5C);
      check(sv, 1);
      check(pf, 1);
      clr = 1;
      @(negedge mclk_i);
      clr = 0;
      @(negedge mclk_i);
      check(pf, 0);
      xt = 1;
      bo = 1;
      repeat (4) @(negedge mclk_i);
      bo = 0;
      to_run(n);
      check(n >= XT, 1);
      check(pf, 1);
      xt = 0;
      $display("power-on tests done");
      for (int i = 0; i < 20; i++) begin
         pa = 16'($random(seed));
         impl = 1'($random(seed));
         raw = 8'($random(seed));
         #1;
         check(rd, (impl && pa <= 16'h0FFF) ? raw : 8'hFF);
         check(we, impl && pa <= 16'h0FFF);
         n = 1 + ($unsigned($random(seed)) % 6);
         hit(0, n, n >= 3);
      end
      hit(1, 1, 1);
      wdm = 0;
      hit(1, 3, 0);
      hit(2, 1, 1);
      stp = 1;
      hit(0, 6, 0);
      hit(3, 2, 1);
      hit(4, 2, 1);
      stp = 0;
      wrap_up();
   end
endmodule : tb
